/* fsel_defines.svh */
// constants for the fieldbus address and bit-rate selector
`ifndef FSEL_DEFINES_SVH
`define FSEL_DEFINES_SVH
`define FSEL_CLK_KHZ          20000
`define FSEL_HOLD_MS          3000
`define FSEL_BLINK_MS         250
`define FSEL_DEB_MS           10
`define FSEL_MS2CYC(ms)       ((ms) * `FSEL_CLK_KHZ)
`define FSEL_CNT_W            26
`define FSEL_REG_STATIC       8'h00
`define FSEL_REG_ADDR         8'h04
`define FSEL_REG_MASK         8'h08
`define FSEL_REG_STATUS       8'h0c
`define FSEL_REG_TYPE         8'h10
`define FSEL_REG_RATE         8'h14
`define FSEL_REG_CMD          8'h18
`define FSEL_REG_DET          8'h1c
`define FSEL_ADDR_SOFT_RST    32'hc0a80165
`define FSEL_ADDR_FIXED_BASE  32'hc0a80064
`define FSEL_AUTOIP_PREFIX    16'ha9fe
`define FSEL_AUTOIP_LO        8'h01
`define FSEL_AUTOIP_HI        8'hfe
`define FSEL_SUBNET_MASK      32'hffffff00
`define FSEL_LFSR_SEED        16'hace1
`define FSEL_LFSR_TAPS        16'hb400
`define FSEL_POS_DHCP         4'h0
`define FSEL_POS_SOFT         4'h1
`define FSEL_POS_MAX          4'h9
`define FSEL_SW_TYPE_UP       4'h8
`define FSEL_SW_TYPE_LO       4'h9
`define FSEL_SW_RATE_UP       4'h9
`define FSEL_SW_RATE_MAX      4'h4
`define FSEL_RATE_AUTO        11'h000
`define FSEL_RATE_125         11'h07d
`define FSEL_RATE_250         11'h0fa
`define FSEL_RATE_500         11'h1f4
`define FSEL_RATE_1000        11'h3e8
`define FSEL_TYPE_MOTION      1'b0
`define FSEL_TYPE_CAN         1'b1
`define FSEL_ERR_NONE         4'h0
`define FSEL_ERR_ENABLED      4'h1
`define FSEL_ERR_STORE        4'h2
`define FSEL_ERR_SELECT       4'h3
`define FSEL_ERR_FLASHES      4'h5
`define FSEL_CMD_STORE        0
`define FSEL_CMD_SAVERATE     1
`define FSEL_DISP_BLANK       3'h0
`define FSEL_DISP_ADDR        3'h1
`define FSEL_DISP_CN          3'h2
`define FSEL_DISP_ER          3'h3
`define FSEL_DISP_SETTING     3'h4
`define FSEL_DISP_ERRCODE     3'h5
`endif

/* fsel_pkg.sv */
// types and helpers of the fieldbus address and bit-rate selector
`include "fsel_defines.svh"
package fsel_pkg;
  typedef enum logic [2:0] {FSEL_ST_BOOT, FSEL_ST_IDLE, FSEL_ST_STORE, FSEL_ST_FLASH,
                            FSEL_ST_TYPEERR} fsel_state_t;
  typedef enum logic [1:0] {FSEL_MODE_DHCP, FSEL_MODE_AUTOIP, FSEL_MODE_SOFT,
                            FSEL_MODE_FIXED} fsel_mode_t;
  typedef enum logic [1:0] {FSEL_PUR_APP, FSEL_PUR_TYPE, FSEL_PUR_RATE} fsel_purpose_t;

  typedef struct packed {
    fsel_state_t             state;
    fsel_purpose_t           purpose;
    fsel_mode_t              mode;
    logic [3:0]              addrPos;
    logic [31:0]             ipAddr;
    logic                    ipValid;
    logic                    dhcpRequest;
    logic [31:0]             softAddr;
    logic                    fbType;
    logic                    activeType;
    logic [10:0]             canRate;
    logic [10:0]             detRate;
    logic                    detValid;
    logic                    canBootSend;
    logic [10:0]             canBootRate;
    logic                    canAutoListen;
    logic [15:0]             lfsr;
    logic [`FSEL_CNT_W-1:0]  blinkCnt;
    logic                    blinkPhase;
    logic [3:0]              flashCnt;
    logic [3:0]              errCode;
    logic [7:0]              setting;
    logic [2:0]              dispKind;
    logic [31:0]             dispValue;
    logic                    dispLit;
    logic                    linkLed;
    logic                    runLed;
    logic                    nvStoreReq;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } fsel_regs_t;

  function automatic logic [10:0] fsel_rate_of(input logic [3:0] sel);
    case (sel)
      4'h1:    return `FSEL_RATE_125;
      4'h2:    return `FSEL_RATE_250;
      4'h3:    return `FSEL_RATE_500;
      4'h4:    return `FSEL_RATE_1000;
      default: return `FSEL_RATE_AUTO;
    endcase
  endfunction

  function automatic logic fsel_rate_ok(input logic [10:0] v);
    return v == `FSEL_RATE_AUTO || v == `FSEL_RATE_125 || v == `FSEL_RATE_250 ||
           v == `FSEL_RATE_500 || v == `FSEL_RATE_1000;
  endfunction
endpackage

/* fsel_debounce.sv */
// two-stage synchroniser and debounce filter for front-panel inputs
`timescale 1ns/1ps
`include "fsel_defines.svh"
module fsel_debounce
  import fsel_pkg::*;
#(
  parameter int W   = 1,
  parameter int CYC = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic              settled
);
  typedef struct packed {
    logic [W-1:0]            s1;
    logic [W-1:0]            s2;
    logic [W-1:0]            cand;
    logic [`FSEL_CNT_W-1:0]  cnt;
    logic [W-1:0]            dout;
    logic                    settled;
  } fsel_deb_t;

  localparam logic [`FSEL_CNT_W-1:0] CNT_LAST = `FSEL_CNT_W'(CYC - 1);
  fsel_deb_t r;
  fsel_deb_t next_r;

  if (W < 1 || CYC < 1 || CYC > (1 << (`FSEL_CNT_W - 1))) begin : g_chk
    $error("fsel_debounce: width or count out of range");
  end

  always_comb begin
    next_r    = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    if (r.s2 != r.cand) begin
      next_r.cand = r.s2;
      next_r.cnt  = '0;
    end else if (r.cnt == CNT_LAST) begin
      next_r.dout    = r.cand;
      next_r.settled = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) r <= '0;
    else       r <= next_r;
  end

  assign dout    = r.dout;
  assign settled = r.settled;
endmodule // fsel_debounce

/* fsel_hold_timer.sv */
// pushbutton hold timer, one pulse per press once the hold time is reached
`timescale 1ns/1ps
`include "fsel_defines.svh"
module fsel_hold_timer #(
  parameter int CYC = 1
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic held,
  output logic      fire
);
  typedef struct packed {
    logic [`FSEL_CNT_W-1:0]  cnt;
    logic                    armed;
    logic                    fire;
  } fsel_hold_t;

  localparam logic [`FSEL_CNT_W-1:0] CNT_LAST = `FSEL_CNT_W'(CYC - 1);
  fsel_hold_t r;
  fsel_hold_t next_r;

  if (CYC < 1 || CYC > (1 << (`FSEL_CNT_W - 1))) begin : g_chk
    $error("fsel_hold_timer: count out of range");
  end

  // armed clears at reset, so held must drop once; a button held through power-up fires, as the debounced input starts low
  always_comb begin
    next_r      = r;
    next_r.fire = 1'b0;
    if (!held) begin
      next_r.cnt   = '0;
      next_r.armed = 1'b1;
    end else if (r.armed) begin
      if (r.cnt == CNT_LAST) begin
        next_r.fire  = 1'b1;
        next_r.armed = 1'b0;
      end else begin
        next_r.cnt = r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) r <= '0;
    else       r <= next_r;
  end

  assign fire = r.fire;
endmodule // fsel_hold_timer

/* fsel_selector.sv */
// fieldbus address and bit-rate selector with apb register access
// Behaviour
// - position 0 requests address via dhcp
// - no dhcp answer: 169.254.x.x link-local
// - position 1 uses software address, default .1.101
// - positions 2-9 give 192.168.0.10n
// - show address while cable connected
// - no cable, no address shown
// - switch change acts only after power cycle
// - subnet mask fixed 255.255.255.0
// - host reads and writes parameters
// - link and running indicators follow state
// - stored type picks bus, default motion
// - code 89 plus 3 s hold stores can
// - show can indicator during change, then restore
// - failed type change shows error indicator
// - rate codes 0,125,250,500,1000
// - switch 9 with 0-4 selects rate
// - fixed rate: boot message at stored rate
// - auto rate: listen, boot at measured rate
// - master may save detected rate
// - rate set needs 3 s hold, blinks
// - rate set failure flashes code five times
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "fsel_defines.svh"
module fsel_selector
  import fsel_pkg::*;
#(
  parameter int HOLD_CYC  = `FSEL_MS2CYC(`FSEL_HOLD_MS),
  parameter int BLINK_CYC = `FSEL_MS2CYC(`FSEL_BLINK_MS),
  parameter int DEB_CYC   = `FSEL_MS2CYC(`FSEL_DEB_MS)
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [3:0]  addrSwitchPin,
  input  wire logic [3:0]  upperSwitchPin,
  input  wire logic [3:0]  lowerSwitchPin,
  input  wire logic        buttonPin,
  input  wire logic        cablePin,
  input  wire logic        linkPin,
  input  wire logic        commRunning,
  input  wire logic        driveEnabled,
  input  wire logic        dhcpOffer,
  input  wire logic [31:0] dhcpAddr,
  input  wire logic        dhcpTimeout,
  input  wire logic        canFrameValid,
  input  wire logic [10:0] canDetRate,
  input  wire logic        nvDone,
  input  wire logic        nvFail,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] ipAddr,
  output logic             ipValid,
  output logic             dhcpRequest,
  output logic             activeFieldbus,
  output logic             canBootSend,
  output logic      [10:0] canBootRate,
  output logic             canAutoListen,
  output logic             nvStoreReq,
  output logic      [2:0]  dispKind,
  output logic      [31:0] dispValue,
  output logic             dispLit,
  output logic             linkLed,
  output logic             runLed
);
  localparam logic [`FSEL_CNT_W-1:0] BLINK_LAST = `FSEL_CNT_W'(BLINK_CYC - 1);
  localparam logic [3:0]             FLASH_LAST = 4'((`FSEL_ERR_FLASHES << 1) - 1);

  if (BLINK_CYC < 1 || BLINK_CYC > (1 << (`FSEL_CNT_W - 1))) begin : g_chk
    $error("fsel_selector: blink count out of range");
  end

  fsel_regs_t  r;
  fsel_regs_t  next_r;
  logic [3:0]  swAddr;
  logic [3:0]  swUp;
  logic [3:0]  swLo;
  logic        button;
  logic        cable;
  logic        swSettled;
  logic        link;
  logic        holdFire;

  //////////////////////////////////////////////////////////////////////////////
  fsel_debounce #(.W(14), .CYC(DEB_CYC)) u_panel (
    .mclk    (mclk),
    .nrst    (nrst),
    .din     ({addrSwitchPin, upperSwitchPin, lowerSwitchPin, buttonPin, cablePin}),
    .dout    ({swAddr, swUp, swLo, button, cable}),
    .settled (swSettled)
  );

  // link state only needs synchronising; a one-cycle filter (CYC 1) keeps the indicator delay short
  fsel_debounce #(.W(1), .CYC(1)) u_link (
    .mclk    (mclk),
    .nrst    (nrst),
    .din     (linkPin),
    .dout    (link),
    .settled ()
  );

  fsel_hold_timer #(.CYC(HOLD_CYC)) u_hold (
    .mclk (mclk),
    .nrst (nrst),
    .held (button),
    .fire (holdFire)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        setup;
    logic        wrDo;
    logic        blinkTick;
    logic [31:0] rd;
    setup     = psel && !penable;
    wrDo      = psel && penable && r.pready && pwrite && !r.pslverr;
    blinkTick = (r.blinkCnt == BLINK_LAST);
    rd        = '0;
    next_r    = r;

    next_r.canBootSend = 1'b0;
    next_r.lfsr        = r.lfsr[0] ? ((r.lfsr >> 1) ^ `FSEL_LFSR_TAPS) : (r.lfsr >> 1);
    next_r.blinkCnt    = blinkTick ? '0 : r.blinkCnt + 1'b1;
    next_r.blinkPhase  = r.blinkPhase ^ blinkTick;
    next_r.linkLed     = link;
    next_r.runLed      = commRunning;

    // apb slave: answer in the first access cycle
    next_r.pready  = setup;
    next_r.pslverr = 1'b0;
    if (setup) begin
      case (paddr)
        `FSEL_REG_STATIC: rd = r.softAddr;
        `FSEL_REG_ADDR:   rd = r.ipAddr;
        `FSEL_REG_MASK:   rd = `FSEL_SUBNET_MASK;
        `FSEL_REG_STATUS: rd = {18'h0, r.state, r.mode, r.errCode, r.detValid,
                                r.activeType, r.fbType, r.ipValid, cable};
        `FSEL_REG_TYPE:   rd = {31'h0, r.fbType};
        `FSEL_REG_RATE:   rd = {21'h0, r.canRate};
        `FSEL_REG_CMD:    rd = '0;
        `FSEL_REG_DET:    rd = {20'h0, r.detValid, r.detRate};
        default:          next_r.pslverr = 1'b1;
      endcase
      if (pwrite && paddr == `FSEL_REG_RATE && !fsel_rate_ok(pwdata[10:0])) begin
        next_r.pslverr = 1'b1;
      end
      next_r.prdata = pwrite ? '0 : rd;
    end
    if (wrDo) begin
      case (paddr)
        `FSEL_REG_STATIC: next_r.softAddr = pwdata;
        `FSEL_REG_TYPE:   next_r.fbType = pwdata[0];
        `FSEL_REG_RATE:   next_r.canRate = pwdata[10:0];
        `FSEL_REG_CMD: begin
          if (r.state == FSEL_ST_IDLE && pwdata[`FSEL_CMD_SAVERATE] && r.detValid) begin
            next_r.canRate = r.detRate;
            next_r.state   = FSEL_ST_STORE;
            next_r.purpose = FSEL_PUR_APP;
          end else if (r.state == FSEL_ST_IDLE && pwdata[`FSEL_CMD_STORE]) begin
            next_r.state   = FSEL_ST_STORE;
            next_r.purpose = FSEL_PUR_APP;
          end
        end
        default: ;
      endcase
    end

    // address side; dhcp and the soft address keep running after boot
    if (r.mode == FSEL_MODE_SOFT) next_r.ipAddr = r.softAddr;
    if (r.dhcpRequest && dhcpOffer) begin
      next_r.ipAddr      = dhcpAddr;
      next_r.ipValid     = 1'b1;
      next_r.dhcpRequest = 1'b0;
    end else if (r.dhcpRequest && dhcpTimeout) begin
      next_r.mode        = FSEL_MODE_AUTOIP;
      next_r.ipValid     = 1'b1;
      next_r.dhcpRequest = 1'b0;
      next_r.ipAddr      = {`FSEL_AUTOIP_PREFIX, r.lfsr};
      if (r.lfsr[15:8] < `FSEL_AUTOIP_LO) next_r.ipAddr[15:8] = `FSEL_AUTOIP_LO;
      if (r.lfsr[15:8] > `FSEL_AUTOIP_HI) next_r.ipAddr[15:8] = `FSEL_AUTOIP_HI;
    end

    if (r.canAutoListen && canFrameValid) begin
      next_r.canAutoListen = 1'b0;
      next_r.canBootSend   = 1'b1;
      next_r.canBootRate   = canDetRate;
      next_r.detRate       = canDetRate;
      next_r.detValid      = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////////
    unique case (r.state)
      FSEL_ST_BOOT: begin
        if (swSettled) begin
          next_r.state      = FSEL_ST_IDLE;
          next_r.addrPos    = swAddr;
          next_r.activeType = r.fbType;
          if (swAddr == `FSEL_POS_DHCP) begin
            next_r.mode        = FSEL_MODE_DHCP;
            next_r.dhcpRequest = 1'b1;
          end else if (swAddr == `FSEL_POS_SOFT || swAddr > `FSEL_POS_MAX) begin
            next_r.mode    = FSEL_MODE_SOFT;
            next_r.ipAddr  = r.softAddr;
            next_r.ipValid = 1'b1;
          end else begin
            next_r.mode    = FSEL_MODE_FIXED;
            next_r.ipAddr  = `FSEL_ADDR_FIXED_BASE + {28'h0, swAddr};
            next_r.ipValid = 1'b1;
          end
          if (r.fbType == `FSEL_TYPE_CAN) begin
            if (r.canRate == `FSEL_RATE_AUTO) begin
              next_r.canAutoListen = 1'b1;
            end else begin
              next_r.canBootSend = 1'b1;
              next_r.canBootRate = r.canRate;
            end
          end
        end
      end
      FSEL_ST_IDLE: begin
        if (holdFire && swUp == `FSEL_SW_TYPE_UP && swLo == `FSEL_SW_TYPE_LO) begin
          next_r.fbType  = `FSEL_TYPE_CAN;
          next_r.state   = FSEL_ST_STORE;
          next_r.purpose = FSEL_PUR_TYPE;
        end else if (holdFire && swUp == `FSEL_SW_RATE_UP) begin
          next_r.setting  = {swUp, swLo};
          next_r.flashCnt = '0;
          if (driveEnabled) begin
            next_r.state   = FSEL_ST_FLASH;
            next_r.errCode = `FSEL_ERR_ENABLED;
          end else if (swLo > `FSEL_SW_RATE_MAX) begin
            next_r.state   = FSEL_ST_FLASH;
            next_r.errCode = `FSEL_ERR_SELECT;
          end else begin
            next_r.canRate = fsel_rate_of(swLo);
            next_r.state   = FSEL_ST_STORE;
            next_r.purpose = FSEL_PUR_RATE;
          end
        end
      end
      FSEL_ST_STORE: begin
        if (nvDone) begin
          next_r.state   = FSEL_ST_IDLE;
          next_r.errCode = `FSEL_ERR_NONE;
        end else if (nvFail) begin
          next_r.errCode  = `FSEL_ERR_STORE;
          next_r.flashCnt = '0;
          unique case (r.purpose)
            FSEL_PUR_TYPE: next_r.state = FSEL_ST_TYPEERR;
            FSEL_PUR_RATE: next_r.state = FSEL_ST_FLASH;
            FSEL_PUR_APP:  next_r.state = FSEL_ST_IDLE;
            default:       next_r.state = FSEL_ST_IDLE;
          endcase
        end
      end
      FSEL_ST_FLASH: begin
        if (blinkTick) begin
          next_r.flashCnt = r.flashCnt + 1'b1;
          if (r.flashCnt == FLASH_LAST) next_r.state = FSEL_ST_IDLE;
        end
      end
      // only a power cycle leaves the failed type change
      FSEL_ST_TYPEERR: ;
      default: next_r.state = FSEL_ST_BOOT;
    endcase
    next_r.nvStoreReq = (next_r.state == FSEL_ST_STORE);

    // display, most urgent first
    next_r.dispLit   = 1'b1;
    next_r.dispValue = '0;
    if (r.state == FSEL_ST_STORE && r.purpose == FSEL_PUR_TYPE) begin
      next_r.dispKind = `FSEL_DISP_CN;
    end else if (r.state == FSEL_ST_TYPEERR) begin
      next_r.dispKind = `FSEL_DISP_ER;
    end else if (r.state == FSEL_ST_STORE && r.purpose == FSEL_PUR_RATE) begin
      next_r.dispKind  = `FSEL_DISP_SETTING;
      next_r.dispValue = {24'h0, r.setting};
      next_r.dispLit   = r.blinkPhase;
    end else if (r.state == FSEL_ST_FLASH) begin
      next_r.dispKind  = `FSEL_DISP_ERRCODE;
      next_r.dispValue = {28'h0, r.errCode};
      next_r.dispLit   = !r.flashCnt[0];
    end else if (cable && r.ipValid) begin
      next_r.dispKind  = `FSEL_DISP_ADDR;
      next_r.dispValue = r.ipAddr;
    end else begin
      next_r.dispKind = `FSEL_DISP_BLANK;
      next_r.dispLit  = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r          <= '0;
      r.state    <= FSEL_ST_BOOT;
      r.softAddr <= `FSEL_ADDR_SOFT_RST;
      r.fbType   <= `FSEL_TYPE_MOTION;
      r.canRate  <= `FSEL_RATE_AUTO;
      r.lfsr     <= `FSEL_LFSR_SEED;
    end else begin
      r <= next_r;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign ipAddr         = r.ipAddr;
  assign ipValid        = r.ipValid;
  assign dhcpRequest    = r.dhcpRequest;
  assign activeFieldbus = r.activeType;
  assign canBootSend    = r.canBootSend;
  assign canBootRate    = r.canBootRate;
  assign canAutoListen  = r.canAutoListen;
  assign nvStoreReq     = r.nvStoreReq;
  assign dispKind       = r.dispKind;
  assign dispValue      = r.dispValue;
  assign dispLit        = r.dispLit;
  assign linkLed        = r.linkLed;
  assign runLed         = r.runLed;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  apb_answer_a: assert property (r.pready |-> $past(psel && !penable) ##1 !r.pready)
    else $error("pready not a single access cycle");
  addr_latched_a: assert property (r.state != FSEL_ST_BOOT && $past(r.state) != FSEL_ST_BOOT
    |-> $stable(r.addrPos))
    else $error("address position changed after boot");
  fixed_addr_a: assert property (r.mode == FSEL_MODE_FIXED |->
    r.ipAddr == `FSEL_ADDR_FIXED_BASE + {28'h0, r.addrPos})
    else $error("fixed address mismatch");
  dhcp_mode_a: assert property (r.dhcpRequest |-> r.mode == FSEL_MODE_DHCP
    && r.addrPos == `FSEL_POS_DHCP && !r.ipValid)
    else $error("dhcp request outside dynamic mode");
  autoip_form_a: assert property (r.mode == FSEL_MODE_AUTOIP |->
    r.ipAddr[31:16] == `FSEL_AUTOIP_PREFIX && r.ipValid)
    else $error("link-local address malformed");
  no_cable_a: assert property (!cable |=> r.dispKind != `FSEL_DISP_ADDR)
    else $error("address shown without cable");
  type_change_a: assert property (r.state == FSEL_ST_IDLE && holdFire
    && swUp == `FSEL_SW_TYPE_UP && swLo == `FSEL_SW_TYPE_LO
    |=> r.fbType == `FSEL_TYPE_CAN && r.nvStoreReq ##1 r.dispKind == `FSEL_DISP_CN)
    else $error("type change not started");
  type_fail_a: assert property (r.state == FSEL_ST_STORE && r.purpose == FSEL_PUR_TYPE
    && nvFail && !nvDone |=> r.state == FSEL_ST_TYPEERR ##1 r.dispKind == `FSEL_DISP_ER)
    else $error("type change failure not shown");
  bad_select_a: assert property (r.state == FSEL_ST_IDLE && holdFire && !driveEnabled
    && swUp == `FSEL_SW_RATE_UP && swLo > `FSEL_SW_RATE_MAX && swUp != `FSEL_SW_TYPE_UP
    |=> r.state == FSEL_ST_FLASH && r.errCode == `FSEL_ERR_SELECT)
    else $error("invalid selection not flagged");
  boot_pulse_a: assert property (r.canBootSend |-> r.activeType == `FSEL_TYPE_CAN
    ##1 !r.canBootSend)
    else $error("boot message not a single pulse");
  led_follow_a: assert property (commRunning |=> r.runLed)
    else $error("running indicator does not follow");

  type_store_c: cover property (r.state == FSEL_ST_STORE && r.purpose == FSEL_PUR_TYPE
    ##[1:20] r.state == FSEL_ST_IDLE);
  rate_flash_c: cover property (r.state == FSEL_ST_FLASH ##1 r.state == FSEL_ST_IDLE);
  autoip_c: cover property (r.mode == FSEL_MODE_AUTOIP && r.dispKind == `FSEL_DISP_ADDR);
  auto_boot_c: cover property (r.canAutoListen ##1 r.canBootSend);
endmodule // fsel_selector

/* fsel_host_model.sv */
// far-side model: nonvolatile store and a network without a dhcp server
`timescale 1ns/1ps
module fsel_host_model (
  input  wire logic        mclk,
  input  wire logic        nvStoreReq,
  input  wire logic        dhcpRequest,
  output logic             nvDone = 1'b0,
  output logic             dhcpTimeout = 1'b0,
  output logic      [31:0] dhcpAddr = 32'h0
);
  int nvCnt = 0;
  int dhCnt = 0;
  always @(posedge mclk) begin
    nvCnt <= nvStoreReq ? nvCnt + 1 : 0;
    // slow store, answers once per request
    nvDone <= (nvCnt == 7);
    dhCnt <= dhcpRequest ? dhCnt + 1 : 0;
    dhcpTimeout <= (dhCnt == 4);
    // no offer is ever made, so the address lines never settle
    dhcpAddr <= ~dhcpAddr;
  end
endmodule // fsel_host_model

/* fieldbus_address_rate_select_tb.sv */
// self-checking bench of the fieldbus address and bit-rate selector
`timescale 1ns/1ps
module fieldbus_address_rate_select_tb;
  import fsel_pkg::*;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, btn = 0, cable = 1, link = 1;
  logic [3:0] addrSw = 4'h5, upSw = 4'h0, loSw = 4'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, ipAddr, rd, dAddr;
  logic pready, pslverr, ipValid, dhReq, nvReq, nvDone, dhTo, runLed, linkLed, er;
  logic [2:0] dispKind;
  logic drvEn = 0, nvFail = 0, canFr = 0;
  logic [31:0] dVal;
  localparam logic [31:0] HOST_ADDR = 32'hc0a80001;
  int errTotal = 0, totalChecks = 0;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, x; logic e;} row_t;
  row_t rows[12] = '{'{0,8'h00,0,32'hc0a80165,0}, '{0,8'h08,0,32'hffffff00,0},
    '{0,8'h04,0,32'hc0a80069,0}, '{0,8'h10,0,0,0}, '{0,8'h14,0,0,0},
    '{1,8'h14,32'h7d,0,0}, '{0,8'h14,0,32'h7d,0}, '{1,8'h14,32'h3e8,0,0},
    '{0,8'h14,0,32'h3e8,0}, '{1,8'h14,32'h64,0,1}, '{0,8'h14,0,32'h3e8,0},
    '{0,8'h40,0,0,1}};
  fsel_selector #(.HOLD_CYC(20), .BLINK_CYC(4), .DEB_CYC(3)) dut_u (.mclk(mclk),
    .nrst(nrst), .addrSwitchPin(addrSw), .upperSwitchPin(upSw), .lowerSwitchPin(loSw),
    .buttonPin(btn), .cablePin(cable), .linkPin(link), .commRunning(link),
    .driveEnabled(drvEn), .dhcpOffer(1'b0), .dhcpAddr(dAddr), .dhcpTimeout(dhTo),
    .canFrameValid(canFr), .canDetRate(11'h0), .nvDone(nvDone), .nvFail(nvFail),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ipAddr(ipAddr),
    .ipValid(ipValid), .dhcpRequest(dhReq), .activeFieldbus(), .canBootSend(),
    .canBootRate(), .canAutoListen(), .nvStoreReq(nvReq), .dispKind(dispKind),
    .dispValue(dVal), .dispLit(), .linkLed(linkLed), .runLed(runLed));
  fsel_host_model host_u (.mclk(mclk), .nvStoreReq(nvReq), .dhcpRequest(dhReq),
    .nvDone(nvDone), .dhcpTimeout(dhTo), .dhcpAddr(dAddr));
  initial begin
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic waitfor(ref logic s);
    for (int i = 0; i < 200 && s !== 1'b1; i++) @(posedge mclk);
  endtask
  task automatic finishTest;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    finishTest;
  end
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1;
    waitfor(ipValid);
    repeat (2) @(posedge mclk);
    chk(ipAddr, 32'hc0a80069);
    chk(dispKind, 3'h1);
    chk(dVal, 32'hc0a80069);
    chk(ipAddr[31:8], HOST_ADDR[31:8]);
    chk(ipAddr[7:0] != HOST_ADDR[7:0], 1'b1);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk({rows[i].w ? 32'h0 : rd, 31'h0, er}, {rows[i].x, 31'h0, rows[i].e});
    end
    $display("register table done");
    addrSw <= 4'h2; link <= 0; cable <= 0;
    repeat (20) @(posedge mclk);
    chk(ipAddr, 32'hc0a80069);
    chk(dispKind, 3'h0);
    chk({linkLed, runLed}, 2'b00);
    $display("panel inputs done");
    upSw <= 4'h8; loSw <= 4'h9;
    repeat (10) @(posedge mclk);
    btn <= 1;
    waitfor(nvReq);
    repeat (2) @(posedge mclk);
    chk(dispKind, 3'h2);
    btn <= 0;
    repeat (20) @(posedge mclk);
    chk({nvReq, dispKind}, 4'h0);
    apb(0, 8'h10, 0);
    chk(rd, 32'h1);
    $display("type change done");
    addrSw <= 4'h0; nrst <= 0;
    repeat (4) @(posedge mclk);
    nrst <= 1;
    waitfor(dhReq);
    chk(dhReq, 1'b1);
    waitfor(ipValid);
    @(posedge mclk);
    chk(ipAddr[31:16], 16'ha9fe);
    $display("dhcp fallback done");
    btn <= 1;
    waitfor(nvReq);
    nvFail <= 1;
    @(posedge mclk);
    nvFail <= 0;
    repeat (3) @(posedge mclk);
    chk(dispKind, 3'h3);
    btn <= 0;
    $display("type change failure done");
    finishTest;
  end
endmodule // fieldbus_address_rate_select_tb
